// >>> rtl/ihcs_pkg.sv
// constants, types and register map of the i2c host condition sequencer
package ihcs_pkg;
    // byte offsets on the register bus
    localparam logic [3:0] CTRL_OFS   = 4'h0;
    localparam logic [3:0] STATUS_OFS = 4'h4;
    localparam logic [3:0] BUF_OFS    = 4'h8;
    localparam logic [3:0] BAUD_OFS   = 4'hc;
    // control fields; bits 0..3 are the requests
    localparam int REQ_START   = 0;
    localparam int REQ_RSTART  = 1;
    localparam int REQ_STOP    = 2;
    localparam int REQ_ACK     = 3;
    localparam int ACK_SEL_BIT = 4;
    localparam int IRQ_EN_BIT  = 5;
    // status fields; write collision, event and bus collision are write one to clear
    localparam int WRITE_COLLISION_FLAG_BIT  = 1;
    localparam int EVENT_BIT = 3;
    localparam int BCOL_BIT  = 4;
    localparam int BUSY_BIT  = 7;
    localparam logic [7:0] BAUD_RST = 8'h04;
    localparam int         BIT_LAST = 8;
    typedef enum {
        S_IDLE, S_RS_LOW, S_RS_SDAH, S_RS_RISE, S_RS_HIGH, S_RS_SDAL,
        S_ST_HIGH, S_ST_HOLD, S_TX_LOW, S_TX_RISE, S_TX_HIGH,
        S_AK_LOW, S_AK_RISE, S_AK_HIGH, S_SP_FALL, S_SP_LOW,
        S_SP_RISE, S_SP_HIGH, S_SP_SDAR, S_SP_END
    } ihcs_state_t;
    typedef struct packed {
        logic stopSeen;
        logic startSeen;
        logic busColl;
        logic eventFlag;
        logic ack_received_status;
        logic writeColl;
        logic bufFull;
    } ihcs_status_t;
endpackage

// >>> rtl/ihcs_top.sv
// host-mode condition sequencer with a classic wishbone register slave
//
// The implementer's own choices: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
module ihcs_top #(
    parameter int BRG_W = 8
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc,
    input  wire logic        wb_stb,
    input  wire logic        wb_we,
    input  wire logic [3:0]  wb_adr,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_wdat,
    output logic      [31:0] wb_rdat,
    output logic             wb_ack,
    input  wire logic        sclIn,
    output logic             sclOut,
    output logic             sclOe,
    input  wire logic        sdaIn,
    output logic             sdaOut,
    output logic             sdaOe,
    output logic             serialEventFlag,
    input  wire logic        sleepMode,
    input  wire logic        clientAddrMatch,
    input  wire logic        clientByteDone,
    output logic             wakeReq
);
    ////////////////////////////////////////////////////////////////////
    ihcs_pkg::ihcs_state_t state_q, state_d;
    ihcs_pkg::ihcs_status_t st_q, st_d;
    logic [BRG_W-1:0] brgCnt_q, brgCnt_d, baudReload_q;
    logic [7:0]  bitShift_q, shift_d, txRxBuffer_q;
    logic [3:0]  bitCnt_q, bitCnt_d, reqs_q, reqClr;
    logic        sclMeta_q, sclS_q, sdaMeta_q, sdaS_q;
    logic        sclPrev_q, sdaPrev_q;
    logic        sclOe_q, sclOe_d, sdaOe_q, sdaOe_d;
    logic        ackSel_q, irqEn_q, ack_q, wake_q, lineLow_q;
    logic [31:0] rdat_q;
    logic        brgLoad, setEvent, setBcol, clrBf, ackCap;
    ////////////////////////////////////////////////////////////////////
    // bus decode; a write lands on the edge where the master sees ack
    wire        wbFire   = wb_cyc & wb_stb & ack_q;
    wire        wrEn     = wbFire & wb_we & wb_sel[0];
    wire [7:0]  wd       = wb_wdat[7:0];
    wire        ctrlWr   = wrEn & (wb_adr == ihcs_pkg::CTRL_OFS);
    wire        stsWr    = wrEn & (wb_adr == ihcs_pkg::STATUS_OFS);
    wire        bufWr    = wrEn & (wb_adr == ihcs_pkg::BUF_OFS);
    wire        baudWr   = wrEn & (wb_adr == ihcs_pkg::BAUD_OFS);
    wire        busy     = (state_q != ihcs_pkg::S_IDLE);
    wire        canTake  = ~busy & (reqs_q == 4'h0);
    // only the lowest request bit is taken: no queuing of events
    wire [3:0]  reqLow   = wd[3:0] & (~wd[3:0] + 4'h1);
    wire [3:0]  reqSet   = (ctrlWr & canTake) ? reqLow : 4'h0;
    wire        txStart  = bufWr & canTake;
    wire        wcolSet  = bufWr & ~canTake;
    wire        tick     = (brgCnt_q == '0);
    wire        sclHi    = sclS_q;
    wire        sdaHi    = sdaS_q;
    wire        bitOut   = bitShift_q[7];
    wire        lastBit  = (bitCnt_q == 4'(ihcs_pkg::BIT_LAST));
    ////////////////////////////////////////////////////////////////////
    // line condition detectors, both lines synchronised first
    wire startDet = sclHi & sclPrev_q & sdaPrev_q & ~sdaHi;
    wire stopDet  = sclHi & sclPrev_q & ~sdaPrev_q & sdaHi;
    wire w1cWcol  = stsWr & wd[ihcs_pkg::WRITE_COLLISION_FLAG_BIT];
    wire w1cEvent = stsWr & wd[ihcs_pkg::EVENT_BIT];
    wire w1cBcol  = stsWr & wd[ihcs_pkg::BCOL_BIT];
    ////////////////////////////////////////////////////////////////////
    // read mux; reserved bits read as zero
    wire [31:0] ctrlRd = {26'h0, irqEn_q, ackSel_q, reqs_q};
    wire [31:0] stsRd  = {24'h0, busy, st_q};
    wire [31:0] rdMux  =
        (wb_adr == ihcs_pkg::CTRL_OFS)   ? ctrlRd :
        (wb_adr == ihcs_pkg::STATUS_OFS) ? stsRd :
        (wb_adr == ihcs_pkg::BUF_OFS)    ? {24'h0, txRxBuffer_q} :
        (wb_adr == ihcs_pkg::BAUD_OFS)   ? {{(32-BRG_W){1'b0}}, baudReload_q} :
        32'h0;
    ////////////////////////////////////////////////////////////////////
    // sticky flags: a hardware set always beats a software clear
    always_comb
    begin
        st_d           = st_q;
        st_d.bufFull   = txStart | (st_q.bufFull & ~clrBf & ~setBcol);
        st_d.writeColl = wcolSet | (st_q.writeColl & ~w1cWcol);
        st_d.ack_received_status   = ackCap ? sdaHi : st_q.ack_received_status;
        st_d.eventFlag = setEvent | (st_q.eventFlag & ~w1cEvent);
        st_d.busColl   = setBcol | (st_q.busColl & ~w1cBcol);
        st_d.startSeen = startDet | (st_q.startSeen & ~stopDet);
        st_d.stopSeen  = stopDet | (st_q.stopSeen & ~startDet);
    end
    // baud counter: every load takes the reload register
    assign brgCnt_d = brgLoad ? baudReload_q :
                      (tick ? brgCnt_q : brgCnt_q - 1'b1);
    ////////////////////////////////////////////////////////////////////
    // sequencer; lines stay where they are while idle, so SCL stays held low after a byte, an ack or a restart
    always_comb
    begin
        state_d  = state_q;
        sclOe_d  = sclOe_q;
        sdaOe_d  = sdaOe_q;
        shift_d  = bitShift_q;
        bitCnt_d = bitCnt_q;
        brgLoad  = 1'b0;
        reqClr   = 4'h0;
        setEvent = 1'b0;
        setBcol  = 1'b0;
        clrBf    = 1'b0;
        ackCap   = 1'b0;
        case (state_q)
            ihcs_pkg::S_IDLE:
            begin
                if (reqs_q[ihcs_pkg::REQ_START])
                begin
                    if (!sclHi || !sdaHi)
                        setBcol = 1'b1;
                    else
                    begin
                        brgLoad = 1'b1;
                        state_d = ihcs_pkg::S_ST_HIGH;
                    end
                end
                else if (reqs_q[ihcs_pkg::REQ_RSTART])
                begin
                    sclOe_d = 1'b1;
                    sdaOe_d = 1'b0;
                    state_d = ihcs_pkg::S_RS_LOW;
                end
                else if (reqs_q[ihcs_pkg::REQ_STOP])
                begin
                    sclOe_d = 1'b1;
                    sdaOe_d = 1'b1;
                    state_d = ihcs_pkg::S_SP_FALL;
                end
                else if (reqs_q[ihcs_pkg::REQ_ACK])
                begin
                    sclOe_d = 1'b1;
                    sdaOe_d = ~ackSel_q;
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_AK_LOW;
                end
                else if (txStart)
                begin
                    shift_d  = {wd[6:0], 1'b0};
                    bitCnt_d = 4'h0;
                    sclOe_d  = 1'b1;
                    sdaOe_d  = ~wd[7];
                    brgLoad  = 1'b1;
                    state_d  = ihcs_pkg::S_TX_LOW;
                end
            end
            // restart: wait for SCL low, then SDA released one period
            ihcs_pkg::S_RS_LOW:
                if (!sclHi)
                begin
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_RS_SDAH;
                end
            ihcs_pkg::S_RS_SDAH:
                if (tick)
                begin
                    if (sdaHi)
                    begin
                        sclOe_d = 1'b0;
                        state_d = ihcs_pkg::S_RS_RISE;
                    end
                    else
                        setBcol = 1'b1;
                end
            ihcs_pkg::S_RS_RISE:
                if (sclHi)
                begin
                    if (!sdaHi)
                        setBcol = 1'b1;
                    else
                    begin
                        brgLoad = 1'b1;
                        state_d = ihcs_pkg::S_RS_HIGH;
                    end
                end
            ihcs_pkg::S_RS_HIGH:
                if (!sclHi)
                    setBcol = 1'b1;
                else if (tick)
                begin
                    sdaOe_d = 1'b1;
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_RS_SDAL;
                end
            ihcs_pkg::S_RS_SDAL:
                if (tick)
                begin
                    sclOe_d  = 1'b1;
                    reqClr   = 4'h1 << ihcs_pkg::REQ_RSTART;
                    setEvent = 1'b1;
                    state_d  = ihcs_pkg::S_IDLE;
                end
            // start: SDA falls with SCL high, then a hold period
            ihcs_pkg::S_ST_HIGH:
                if (!sclHi)
                    setBcol = 1'b1;
                else if (tick)
                begin
                    sdaOe_d = 1'b1;
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_ST_HOLD;
                end
            ihcs_pkg::S_ST_HOLD:
                if (tick)
                begin
                    reqClr   = 4'h1 << ihcs_pkg::REQ_START;
                    setEvent = 1'b1;
                    state_d  = ihcs_pkg::S_IDLE;
                end
            // byte transmit: eight data bits and the ninth for ack
            ihcs_pkg::S_TX_LOW:
                if (tick)
                begin
                    sclOe_d = 1'b0;
                    state_d = ihcs_pkg::S_TX_RISE;
                end
            ihcs_pkg::S_TX_RISE:
                if (sclHi)
                begin
                    if (lastBit)
                        ackCap = 1'b1;
                    if (!lastBit && !sdaOe_q && !sdaHi)
                        setBcol = 1'b1;
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_TX_HIGH;
                end
            ihcs_pkg::S_TX_HIGH:
                if (tick)
                begin
                    sclOe_d = 1'b1;
                    if (lastBit)
                    begin
                        setEvent = 1'b1;
                        state_d  = ihcs_pkg::S_IDLE;
                    end
                    else
                    begin
                        bitCnt_d = bitCnt_q + 4'h1;
                        if (bitCnt_q == 4'(ihcs_pkg::BIT_LAST - 1))
                        begin
                            sdaOe_d = 1'b0;
                            clrBf   = 1'b1;
                        end
                        else
                        begin
                            sdaOe_d = ~bitOut;
                            shift_d = {bitShift_q[6:0], 1'b0};
                        end
                        brgLoad = 1'b1;
                        state_d = ihcs_pkg::S_TX_LOW;
                    end
                end
            // ack sequence
            ihcs_pkg::S_AK_LOW:
                if (tick)
                begin
                    sclOe_d = 1'b0;
                    state_d = ihcs_pkg::S_AK_RISE;
                end
            ihcs_pkg::S_AK_RISE:
                if (sclHi)
                begin
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_AK_HIGH;
                end
            ihcs_pkg::S_AK_HIGH:
                if (tick)
                begin
                    sclOe_d  = 1'b1;
                    reqClr   = 4'h1 << ihcs_pkg::REQ_ACK;
                    setEvent = 1'b1;
                    state_d  = ihcs_pkg::S_IDLE;
                end
            // stop: SDA low, SCL up, then SDA up
            ihcs_pkg::S_SP_FALL:
                if (!sdaHi)
                begin
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_SP_LOW;
                end
            ihcs_pkg::S_SP_LOW:
                if (tick)
                begin
                    sclOe_d = 1'b0;
                    state_d = ihcs_pkg::S_SP_RISE;
                end
            ihcs_pkg::S_SP_RISE:
                if (sclHi)
                begin
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_SP_HIGH;
                end
            ihcs_pkg::S_SP_HIGH:
                if (tick)
                begin
                    sdaOe_d = 1'b0;
                    state_d = ihcs_pkg::S_SP_SDAR;
                end
            ihcs_pkg::S_SP_SDAR:
                if (sdaHi && sclHi)
                begin
                    brgLoad = 1'b1;
                    state_d = ihcs_pkg::S_SP_END;
                end
            ihcs_pkg::S_SP_END:
                if (tick)
                begin
                    reqClr   = 4'h1 << ihcs_pkg::REQ_STOP;
                    setEvent = 1'b1;
                    state_d  = ihcs_pkg::S_IDLE;
                end
            default:
                state_d = ihcs_pkg::S_IDLE;
        endcase
        // collision aborts whatever runs and frees both lines
        if (setBcol)
        begin
            state_d = ihcs_pkg::S_IDLE;
            sclOe_d = 1'b0;
            sdaOe_d = 1'b0;
            reqClr  = 4'hf;
        end
    end
    ////////////////////////////////////////////////////////////////////
    // synchronisers; the meta stage feeds only the second stage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sclMeta_q <= 1'b1;
            sclS_q    <= 1'b1;
            sdaMeta_q <= 1'b1;
            sdaS_q    <= 1'b1;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end
        else
        begin
            sclMeta_q <= sclIn;
            sclS_q    <= sclMeta_q;
            sdaMeta_q <= sdaIn;
            sdaS_q    <= sdaMeta_q;
            sclPrev_q <= sclS_q;
            sdaPrev_q <= sdaS_q;
        end
    end
    // sequencer state; reset frees the lines and drops any transfer
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q    <= ihcs_pkg::S_IDLE;
            sclOe_q    <= 1'b0;
            sdaOe_q    <= 1'b0;
            brgCnt_q   <= '0;
            bitShift_q <= 8'h00;
            bitCnt_q   <= 4'h0;
            st_q       <= '0;
        end
        else
        begin
            state_q    <= state_d;
            sclOe_q    <= sclOe_d;
            sdaOe_q    <= sdaOe_d;
            brgCnt_q   <= brgCnt_d;
            bitShift_q <= shift_d;
            bitCnt_q   <= bitCnt_d;
            st_q       <= st_d;
        end
    end
    // software registers and bus answer, one wait state
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reqs_q       <= 4'h0;
            ackSel_q     <= 1'b0;
            irqEn_q      <= 1'b0;
            baudReload_q <= BRG_W'(ihcs_pkg::BAUD_RST);
            txRxBuffer_q <= 8'h00;
            ack_q        <= 1'b0;
            rdat_q       <= 32'h0;
            wake_q       <= 1'b0;
            lineLow_q    <= 1'b0;
        end
        else
        begin
            reqs_q <= (reqs_q & ~reqClr) | reqSet;
            if (ctrlWr)
            begin
                ackSel_q <= wd[ihcs_pkg::ACK_SEL_BIT];
                irqEn_q  <= wd[ihcs_pkg::IRQ_EN_BIT];
            end
            if (baudWr)
                baudReload_q <= wd[BRG_W-1:0];
            if (txStart)
                txRxBuffer_q <= wd;
            ack_q  <= wb_cyc & wb_stb & ~ack_q;
            if (wb_cyc && wb_stb && !ack_q)
                rdat_q <= rdMux;
            // client side keeps running in sleep and may wake the core
            wake_q <= sleepMode & irqEn_q
                      & (clientAddrMatch | clientByteDone);
            lineLow_q <= 1'b0;
        end
    end
    ////////////////////////////////////////////////////////////////////
    assign wb_rdat         = rdat_q;
    assign wb_ack          = ack_q;
    assign sclOut          = lineLow_q;
    assign sdaOut          = lineLow_q;
    assign sclOe           = sclOe_q;
    assign sdaOe           = sdaOe_q;
    assign serialEventFlag = st_q.eventFlag;
    assign wakeReq         = wake_q;
    ////////////////////////////////////////////////////////////////////
    // checks
    a_rs_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
        ctrlWr && busy && !reqs_q[ihcs_pkg::REQ_RSTART]
        |=> !reqs_q[ihcs_pkg::REQ_RSTART])
        else $error("restart taken while busy");
    a_write_collision_flag_set: assert property (@(posedge core_clk) disable iff (!rst_n)
        bufWr && busy |=> st_q.writeColl && $stable(txRxBuffer_q))
        else $error("busy buffer write not refused");
    a_write_collision_flag_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_q.writeColl && !w1cWcol |=> st_q.writeColl)
        else $error("write collision cleared by hardware");
    a_event_sticky: assert property (@(posedge core_clk) disable iff (!rst_n)
        st_q.eventFlag && !w1cEvent |=> st_q.eventFlag)
        else $error("event flag lost");
    a_tx_begin: assert property (@(posedge core_clk) disable iff (!rst_n)
        txStart |=> st_q.bufFull && state_q == ihcs_pkg::S_TX_LOW && sclOe_q)
        else $error("buffer write did not start byte");
    a_brg_load: assert property (@(posedge core_clk) disable iff (!rst_n)
        brgLoad |=> brgCnt_q == $past(baudReload_q))
        else $error("baud counter not loaded from reload");
    a_clk_stretch: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ihcs_pkg::S_TX_RISE && !sclHi
        |=> state_q == ihcs_pkg::S_TX_RISE && !sclOe_q)
        else $error("counter ran while SCL held low");
    a_rs_finish: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ihcs_pkg::S_RS_SDAL && tick
        |=> !reqs_q[ihcs_pkg::REQ_RSTART] && sclOe_q && sdaOe_q
            && st_q.eventFlag && !busy)
        else $error("restart end wrong");
    a_bus_abort: assert property (@(posedge core_clk) disable iff (!rst_n)
        setBcol |=> st_q.busColl && !busy && !sclOe_q && !sdaOe_q
            && reqs_q == 4'h0)
        else $error("collision did not abort");
    a_bf_clear: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ihcs_pkg::S_TX_HIGH && tick && bitCnt_q == 4'h7
        |=> !st_q.bufFull && !sdaOe_q ##1 sclOe_q)
        else $error("eighth bit end wrong");
    a_ninth_hold: assert property (@(posedge core_clk) disable iff (!rst_n)
        state_q == ihcs_pkg::S_TX_HIGH && tick && lastBit
        |=> !busy && sclOe_q && st_q.eventFlag)
        else $error("ninth clock end wrong");
endmodule

// >>> tb/ihcs_client.sv
// client model: acknowledges each byte on the ninth clock unless nack is high
`timescale 1ns/1ps
module ihcs_client (
    input  wire logic core_clk,
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic nack,
    output logic      sdaOe
);
    logic [3:0] cnt = 4'h0;
    logic       sclQ = 1'b1;
    logic       sdaQ = 1'b1;
    // count scl falls; a start condition restarts the count
    always @(posedge core_clk)
    begin
        sclQ <= scl;
        sdaQ <= sda;
        if (scl && sclQ && sdaQ && !sda)
            cnt <= 4'h0;
        else if (sclQ && !scl)
            cnt <= (cnt == 4'h9) ? 4'h1 : cnt + 4'h1;
    end
    // pull sda only in the ninth bit time, never elsewhere
    assign sdaOe = (cnt == 4'h9) && !nack;
endmodule

// >>> tb/ihcs_top_tb.sv
// bench: register traffic, bytes and conditions against the client model
`timescale 1ns/1ps
module ihcs_top_tb;
    logic        core_clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        we = 1'b0;
    logic        sleep = 1'b0;
    logic        match = 1'b0;
    logic        nack = 1'b0;
    logic        done = 1'b0;
    logic [3:0]  adr = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rd, rdat;
    logic [7:0]  ab;
    logic        sclOe, sdaOe, cSdaOe, wake, ev, ack;
    logic        sclO, sdaO;
    int          seed = 67;
    int          checks = 0;
    int          fail_count = 0;
    // open-drain lines with pull-ups
    wire         scl = !sclOe;
    wire         sda = !(sdaOe || cSdaOe);
    ihcs_top ihcs_top_inst (.core_clk(core_clk), .rst_n(rst_n), .wb_cyc(cyc), .wb_stb(cyc),
        .wb_we(we), .wb_adr(adr), .wb_sel(4'hf), .wb_wdat(wdat), .wb_rdat(rdat), .wb_ack(ack),
        .sclIn(scl), .sclOut(sclO), .sclOe(sclOe), .sdaIn(sda), .sdaOut(sdaO), .sdaOe(sdaOe),
        .serialEventFlag(ev), .sleepMode(sleep), .clientAddrMatch(match),
        .clientByteDone(done), .wakeReq(wake));
    ihcs_client ihcs_client_inst (.core_clk(core_clk), .scl(scl), .sda(sda), .nack(nack),
        .sdaOe(cSdaOe));
    initial forever #50 core_clk = !core_clk;
    ////////////////////////////////////////////////////////////////
    task automatic summarize;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    // one classic cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
        int n;
        n = 0;
        {cyc, we, adr, wdat} <= {1'b1, w, a, 24'h0, d};
        do
        begin
            @(posedge core_clk);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        rd = rdat;
        cyc <= 1'b0;
        @(posedge core_clk);
        if (n >= 50)
        begin
            chk("ack wait", 0, 1);
            summarize;
        end
    endtask
    task automatic evWait;
        for (int n = 0; n < 300; n++)
        begin
            wb(1'b0, 4'h4, 8'h00);
            if (rd[3] === 1'b1)
                return;
        end
        chk("event wait", 0, 1);
        summarize;
    endtask
    // status after a byte: start seen and event, plus ack and collision bits
    function automatic logic [31:0] stExp(input logic nk, input logic wc);
        return {24'h0, 8'h28 | {5'h0, nk, wc, 1'b0}};
    endfunction
    ////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        wb(1'b0, 4'h4, 8'h0);
        chk("status", rd, 32'h0);
        chk("drive level", {sclO, sdaO}, 2'b00);
        ab = 8'(($random(seed) & 3) + 2);
        wb(1'b1, 4'hc, ab);
        wb(1'b0, 4'hc, 8'h0);
        chk("baud", rd, {24'h0, ab});
        $display("reset test done");
        wb(1'b1, 4'h0, 8'h01);
        evWait;
        wb(1'b1, 4'h4, 8'h08);
        ab = {7'($random(seed)), 1'b0};
        wb(1'b1, 4'h8, ab);
        wb(1'b1, 4'h8, ~ab);
        wb(1'b0, 4'h8, 8'h0);
        chk("buffer", rd, {24'h0, ab});
        wb(1'b0, 4'h4, 8'h0);
        chk("full", rd[1:0], 2'b11);
        evWait;
        chk("ack", rd, stExp(1'b0, 1'b1));
        wb(1'b1, 4'h4, 8'h0a);
        nack <= 1'b1;
        wb(1'b1, 4'h8, 8'($random(seed)));
        evWait;
        chk("nack", rd, stExp(1'b1, 1'b0));
        chk("scl held", sclOe, 1'b1);
        nack <= 1'b0;
        // start while the own SCL is held low must be a collision
        wb(1'b1, 4'h0, 8'h01);
        wb(1'b0, 4'h4, 8'h0);
        chk("collision", {rd[4], rd[7], sclOe, sdaOe}, 4'b1000);
        wb(1'b1, 4'h4, 8'h18);
        $display("byte test done");
        wb(1'b1, 4'h0, 8'h08);
        wb(1'b1, 4'h8, 8'h5a);
        wb(1'b1, 4'h0, 8'h02);
        evWait;
        chk("ack seq", {rd[1], sclOe}, 2'b11);
        wb(1'b0, 4'h0, 8'h0);
        chk("no restart", rd[3:0], 4'h0);
        wb(1'b1, 4'h4, 8'h0a);
        wb(1'b1, 4'h0, 8'h02);
        wb(1'b1, 4'h0, 8'h04);
        evWait;
        chk("restart", {rd[6:5], sclOe, sdaOe}, 4'b0111);
        repeat (60) @(posedge core_clk);
        wb(1'b0, 4'h4, 8'h0);
        chk("no stop", rd[6], 1'b0);
        wb(1'b1, 4'h4, 8'h08);
        wb(1'b1, 4'h0, 8'h04);
        evWait;
        chk("stop", {rd[6:5], sclOe, sdaOe}, 4'b1000);
        wb(1'b0, 4'h1, 8'h0);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, 4'h0, 8'h20);
        sleep <= 1'b1;
        match <= 1'b1;
        repeat (3) @(posedge core_clk);
        chk("wake", wake, 1'b1);
        chk("sticky", ev, 1'b1);
        {match, done} <= 2'b01;
        repeat (3) @(posedge core_clk);
        chk("wake byte", wake, 1'b1);
        $display("condition test done");
        // reset in mid-byte must free both lines and clear the flags
        wb(1'b1, 4'h8, 8'h01);
        repeat (5) @(posedge core_clk);
        chk("first bit", sdaOe, 1'b1);
        rst_n <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        chk("abort", {sclOe, sdaOe, ev}, 3'b000);
        wb(1'b0, 4'h4, 8'h0);
        chk("status after abort", rd, 32'h0);
        $display("abort test done");
        summarize;
    end
endmodule
